//--- logic/sadc_pkg.sv
/*
  package for the converter digital interface: register map, field
  positions, reset values, mode codes and the carrier structs.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sadc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CONTROL = 32'hffff0500;
  localparam logic [31:0] ADDR_POS_SEL = 32'hffff0504;
  localparam logic [31:0] ADDR_NEG_SEL = 32'hffff0508;
  localparam logic [31:0] ADDR_STATUS = 32'hffff050c;
  localparam logic [31:0] ADDR_RESULT = 32'hffff0510;
  localparam logic [31:0] ADDR_SOFT_RST = 32'hffff0514;
  localparam logic [31:0] ADDR_GAIN = 32'hffff0530;
  localparam logic [31:0] ADDR_OFFSET = 32'hffff0534;

  // ----------------------------------------------------------------
  // reset values and trim layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [4:0] RST_SEL = 5'h00;
  localparam logic [9:0] RST_TRIM = 10'h200;
  localparam logic [31:0] RST_RESULT = 32'h00000000;
  localparam int TRIM_W = 10;
  localparam int CODE_W = 12;
  localparam int RES_LSB = 16;
  localparam int RES_MSB = 27;
  localparam int READY_BIT = 0;
  localparam int SEL_W = 5;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_BUSY_EN = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_START_LSB = 3;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DIFF = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;
  localparam logic [2:0] START_NONE = 3'h0;
  localparam logic [2:0] START_ONCE = 3'h1;
  localparam logic [2:0] START_CONT = 3'h2;
  localparam logic [2:0] START_PIN = 3'h3;
  localparam logic [2:0] START_LOGIC = 3'h4;
  localparam logic [2:0] START_TMR_A = 3'h5;
  localparam logic [2:0] START_TMR_B = 3'h6;

  // ----------------------------------------------------------------
  // mux codes and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] SEL_TEMP = 5'h10;
  localparam logic [4:0] SEL_INT_REF = 5'h10;
  localparam int ACQ_CYCLES = 8;

  // peripheral bus request
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sadc_bus_type;

  // face toward the analog front end
  typedef struct packed {
    logic track;
    logic tempSel;
    logic [4:0] posSel;
    logic [4:0] negSel;
    logic [1:0] mode;
    logic [11:0] dacCode;
  } sadc_afe_type;

endpackage

//--- logic/sadc_sar_engine.sv
/*
  successive approximation sequencer: acquisition, then bit trials
  from the msb down against the comparator.
  assumes comp is synchronous and settles within one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_sar_engine #(
  parameter int ACQ = sadc_pkg::ACQ_CYCLES,
  parameter int W = sadc_pkg::CODE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clr,
  // control
  input wire logic start,
  input wire logic comp,
  // status and data
  output logic busy,
  output logic track,
  output logic done,
  output logic [W-1:0] trial,
  output logic [W-1:0] code
);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ACQ = 4'b0010,
    S_CONV = 4'b0100,
    S_DONE = 4'b1000
  } sadc_state_type;

  sadc_state_type state_r;
  logic [7:0] acq_r;
  logic [W-1:0] bit_r;
  logic [W-1:0] sar_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      acq_r <= 8'h00;
      bit_r <= '0;
      sar_r <= '0;
      code <= '0;
    end else if (ce) begin
      if (clr) begin
        state_r <= S_IDLE;
        sar_r <= '0;
        code <= '0;
      end else begin
        unique case (state_r)
          S_IDLE: begin
            if (start) begin
              state_r <= S_ACQ;
              acq_r <= 8'(ACQ - 1);
            end
          end
          S_ACQ: begin
            if (acq_r == 8'h00) begin
              // inputs released, trials begin
              state_r <= S_CONV;
              bit_r <= {1'b1, {(W-1){1'b0}}};
              sar_r <= '0;
            end else begin
              acq_r <= acq_r - 8'h01;
            end
          end
          S_CONV: begin
            if (comp) begin
              sar_r <= sar_r | bit_r; // keep bit
            end
            bit_r <= bit_r >> 1;
            if (bit_r[0]) begin
              state_r <= S_DONE;
              code <= comp ? (sar_r | bit_r) : sar_r;
            end
          end
          S_DONE: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // trial code, tracking and busy
  assign trial = sar_r | bit_r;
  assign track = (state_r == S_IDLE) || (state_r == S_ACQ);
  assign busy = (state_r == S_ACQ) || (state_r == S_CONV);
  assign done = ce && (state_r == S_DONE);

endmodule
`default_nettype wire

//--- logic/sadc_interface.sv
/*
  digital interface of the 12-bit converter: register file on the
  two-cycle peripheral bus, start sources, trim correction, result
  coding, ready flag, busy output and soft reset.
  assumes all inputs are synchronous to clk; start pulses are one
  cycle wide, the start pin is a level sampled for rising edges.
*/
// Functional notes
// - temperature sensor selectable as extra mux input
// - single/pseudo mode results straight binary
// - differential mode results twos complement
// - differential result stored shifted right one
// - negative select: inputs, dacs, internal reference
// - end of conversion sets ready, raises interrupt
// - reading result clears ready flag
// - busy high throughout every conversion
// - busy on port0_bit5 only when enabled
// - result register read-only, twelve bits, resets zero
// - any soft reset write restores all defaults
// - gain trim ten bits, default 0x200
// - offset trim ten bits, default 0x200
// - trims reset to factory coefficients
// - sampled inputs disconnected, then successive approximation
// - offset correction quarter lsb steps, 3.125 percent
// - gain correction quarter lsb steps, 3.125 percent
// - start by software, pin, logic, timers
// - register access takes two bus cycles
`timescale 1ns/1ps
`default_nettype none
module sadc_interface #(
  parameter int ACQ = sadc_pkg::ACQ_CYCLES,
  parameter logic [9:0] GAIN_DEFAULT = sadc_pkg::RST_TRIM,
  parameter logic [9:0] OFFSET_DEFAULT = sadc_pkg::RST_TRIM
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // peripheral register bus
  input wire sadc_pkg::sadc_bus_type bus,
  output logic [31:0] busRdata,
  output logic busReady,
  // start sources
  input wire logic extConvertTrigger,
  input wire logic logicArrayStart,
  input wire logic timerAOverflow,
  input wire logic timerBOverflow,
  // analog front end
  input wire logic comp,
  output sadc_pkg::sadc_afe_type afe,
  // status outputs
  output logic convIrq,
  output logic convBusy,
  output logic port0Bit5,
  output logic port0Bit5Oe
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wrAcc;
  logic rdAcc;
  logic softClr;
  logic hitResult;

  // second cycle of a bus transfer is the access phase
  assign access = ce && bus.sel && bus.en;
  assign wrAcc = access && bus.wr;
  assign rdAcc = access && !bus.wr;
  assign busReady = bus.sel && bus.en;
  assign hitResult = bus.addr == sadc_pkg::ADDR_RESULT;
  assign softClr = wrAcc && (bus.addr == sadc_pkg::ADDR_SOFT_RST);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [7:0] control_r;
  logic [4:0] posSel_r;
  logic [4:0] negSel_r;
  logic [9:0] gain_r;
  logic [9:0] offset_r;
  logic onceReq_r;

  // control and mux selects
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control_r <= sadc_pkg::RST_CONTROL;
      posSel_r <= sadc_pkg::RST_SEL;
      negSel_r <= sadc_pkg::RST_SEL;
    end else if (ce) begin
      if (softClr) begin
        control_r <= sadc_pkg::RST_CONTROL;
        posSel_r <= sadc_pkg::RST_SEL;
        negSel_r <= sadc_pkg::RST_SEL;
      end else if (wrAcc) begin
        if (bus.addr == sadc_pkg::ADDR_CONTROL) begin
          control_r <= bus.wdata[7:0];
        end
        if (bus.addr == sadc_pkg::ADDR_POS_SEL) begin
          posSel_r <= bus.wdata[4:0]; // temp sensor code accepted
        end
        if (bus.addr == sadc_pkg::ADDR_NEG_SEL) begin
          negSel_r <= bus.wdata[4:0]; // bits 7:5 dropped
        end
      end
    end
  end

  // trim registers, factory defaults after any reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_r <= GAIN_DEFAULT;
      offset_r <= OFFSET_DEFAULT;
    end else if (ce) begin
      if (softClr) begin
        gain_r <= GAIN_DEFAULT;
        offset_r <= OFFSET_DEFAULT;
      end else if (wrAcc) begin
        if (bus.addr == sadc_pkg::ADDR_GAIN) begin
          gain_r <= bus.wdata[9:0];
        end
        if (bus.addr == sadc_pkg::ADDR_OFFSET) begin
          offset_r <= bus.wdata[9:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // start sources
  // ----------------------------------------------------------------
  logic [2:0] startSrc;
  logic [1:0] mode;
  logic busyEn;
  logic pinLast_r;
  logic pinRise;
  logic engBusy;
  logic engDone;
  logic startReq;
  logic ctlWrite;

  assign startSrc = control_r[sadc_pkg::CTL_START_LSB +: 3];
  assign mode = control_r[sadc_pkg::CTL_MODE_LSB +: 2];
  assign busyEn = control_r[sadc_pkg::CTL_BUSY_EN];
  assign pinRise = extConvertTrigger && !pinLast_r;
  assign ctlWrite = wrAcc && (bus.addr == sadc_pkg::ADDR_CONTROL);

  // start pin edge detect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinLast_r <= 1'b0;
    end else if (ce) begin
      pinLast_r <= extConvertTrigger;
    end
  end

  // single software conversion armed by a control write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      onceReq_r <= 1'b0;
    end else if (ce) begin
      if (softClr) begin
        onceReq_r <= 1'b0;
      end else if (ctlWrite) begin
        onceReq_r <= bus.wdata[sadc_pkg::CTL_START_LSB +: 3] == sadc_pkg::START_ONCE;
      end else if (!engBusy) begin
        onceReq_r <= 1'b0;
      end
    end
  end

  // start selection
  always_comb begin
    startReq = 1'b0;
    unique case (startSrc)
      sadc_pkg::START_ONCE: startReq = onceReq_r;
      sadc_pkg::START_CONT: startReq = 1'b1;
      sadc_pkg::START_PIN: startReq = pinRise;
      sadc_pkg::START_LOGIC: startReq = logicArrayStart;
      sadc_pkg::START_TMR_A: startReq = timerAOverflow;
      sadc_pkg::START_TMR_B: startReq = timerBOverflow;
      default: startReq = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // conversion engine
  // ----------------------------------------------------------------
  logic engTrack;
  logic [11:0] engTrial;
  logic [11:0] engCode;

  sadc_sar_engine #(
    .ACQ(ACQ),
    .W(sadc_pkg::CODE_W)
  ) u_engine (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .clr(softClr),
    .start(startReq && !softClr),
    .comp(comp),
    .busy(engBusy),
    .track(engTrack),
    .done(engDone),
    .trial(engTrial),
    .code(engCode)
  );

  // front end drive, temperature sensor on positive code
  always_comb begin
    afe.track = engTrack;
    afe.tempSel = posSel_r == sadc_pkg::SEL_TEMP;
    afe.posSel = posSel_r;
    afe.negSel = negSel_r;
    afe.mode = mode;
    afe.dacCode = engTrial;
  end

  // ----------------------------------------------------------------
  // trim correction, working in quarter lsb
  // ----------------------------------------------------------------
  function automatic logic [11:0] trimCorrect(
    input logic [11:0] raw,
    input logic [9:0] gain,
    input logic [9:0] offs
  );
    logic signed [11:0] gd;
    logic signed [11:0] od;
    logic signed [25:0] prod;
    logic signed [19:0] q;
    gd = $signed({2'b00, gain}) - 12'sd512;
    od = $signed({2'b00, offs}) - 12'sd512;
    prod = $signed({1'b0, raw}) * gd;
    // gain term: full scale moves by one quarter lsb per step
    q = $signed({6'b0, raw, 2'b00}) + 20'(prod >>> 12) + 20'(od) + 20'sd2;
    q = q >>> 2;
    if (q < 20'sd0) begin
      trimCorrect = 12'h000;
    end else if (q > 20'sd4095) begin
      trimCorrect = 12'hfff;
    end else begin
      trimCorrect = q[11:0];
    end
  endfunction

  // result coding per input mode
  logic [11:0] corrected;
  logic [11:0] twos;
  logic [31:0] resultWord;

  assign corrected = trimCorrect(engCode, gain_r, offset_r);
  assign twos = corrected ^ 12'h800;

  always_comb begin
    resultWord = sadc_pkg::RST_RESULT;
    if (mode == sadc_pkg::MODE_DIFF) begin
      // signed value shifted right one, sign filled above
      resultWord[sadc_pkg::RES_MSB:sadc_pkg::RES_LSB] = {twos[11], twos[11:1]};
      resultWord[31:28] = {4{twos[11]}};
    end else begin
      resultWord[sadc_pkg::RES_MSB:sadc_pkg::RES_LSB] = corrected;
    end
  end

  // ----------------------------------------------------------------
  // result register and ready flag
  // ----------------------------------------------------------------
  logic [31:0] result_r;
  logic ready_r;
  logic doneSeen;

  // engine done rises on the same edge that loads engine code, so code is final
  assign doneSeen = engDone && !softClr;

  // result capture, read-only to software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= sadc_pkg::RST_RESULT;
    end else if (ce) begin
      if (softClr) begin
        result_r <= sadc_pkg::RST_RESULT;
      end else if (doneSeen) begin
        result_r <= resultWord;
      end
    end
  end

  // ready flag: set on done, cleared by result read, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r <= 1'b0;
    end else if (ce) begin
      if (softClr) begin
        ready_r <= 1'b0;
      end else if (doneSeen) begin
        ready_r <= 1'b1;
      end else if (rdAcc && hitResult) begin
        ready_r <= 1'b0;
      end
    end
  end

  assign convIrq = ready_r;

  // ----------------------------------------------------------------
  // busy outputs
  // ----------------------------------------------------------------
  assign convBusy = engBusy;
  assign port0Bit5 = busyEn && engBusy;
  assign port0Bit5Oe = busyEn;

  // ----------------------------------------------------------------
  // read data, loaded in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rdNxt;

  always_comb begin
    rdNxt = 32'h00000000;
    unique case (bus.addr)
      sadc_pkg::ADDR_CONTROL: rdNxt[7:0] = control_r;
      sadc_pkg::ADDR_POS_SEL: rdNxt[4:0] = posSel_r;
      sadc_pkg::ADDR_NEG_SEL: rdNxt[4:0] = negSel_r;
      sadc_pkg::ADDR_STATUS: rdNxt[sadc_pkg::READY_BIT] = ready_r;
      sadc_pkg::ADDR_RESULT: rdNxt = result_r;
      sadc_pkg::ADDR_GAIN: rdNxt[9:0] = gain_r;
      sadc_pkg::ADDR_OFFSET: rdNxt[9:0] = offset_r;
      default: rdNxt = 32'h00000000;
    endcase
  end

  // read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= 32'h00000000;
    end else if (ce) begin
      if (bus.sel && !bus.en && !bus.wr) begin
        busRdata <= rdNxt;
      end
    end
  end

endmodule
`default_nettype wire

//--- verif/sadc_interface_props.sv
/*
  concurrent checks on the converter interface ports.
  assumes a bind onto the interface top and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_interface_props #(
  parameter int ACQ = sadc_pkg::ACQ_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // register bus
  input wire sadc_pkg::sadc_bus_type bus,
  input wire logic [31:0] busRdata,
  input wire logic busReady,
  // status and front end
  input wire logic convIrq,
  input wire logic convBusy,
  input wire logic port0Bit5,
  input wire logic port0Bit5Oe,
  input wire sadc_pkg::sadc_afe_type afe
);
  // ------------------------------------------------------------
  // access decode and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic rdAcc;
  logic rstWr;
  // read access and soft reset write in the access phase
  assign rdAcc = bus.sel && bus.en && ce && !bus.wr;
  assign rstWr = bus.sel && bus.en && ce && bus.wr && bus.addr == sadc_pkg::ADDR_SOFT_RST;

  property p_ready; bus.sel && bus.en |-> busReady; endproperty
  a_ready: assert property (p_ready) else $error("bus ready missing");
  property p_status;
    rdAcc && bus.addr == sadc_pkg::ADDR_STATUS |-> busRdata == {31'h0, $past(convIrq)};
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_rdClr;
    rdAcc && bus.addr == sadc_pkg::ADDR_RESULT && !convBusy && !$past(convBusy) |=> !convIrq;
  endproperty
  a_rdClr: assert property (p_rdClr) else $error("ready kept after read");
  property p_endRdy; $fell(convBusy) && !$past(rstWr) |-> ##[0:2] convIrq; endproperty
  a_endRdy: assert property (p_endRdy) else $error("no ready at end");
  property p_busyLen; $rose(convBusy) |-> convBusy [*8]; endproperty
  a_busyLen: assert property (p_busyLen) else $error("busy dropped early");
  property p_acq; $rose(convBusy) |-> afe.track ##ACQ !afe.track; endproperty
  a_acq: assert property (p_acq) else $error("acquisition length wrong");
  property p_msb; $fell(afe.track) |-> afe.dacCode == 12'h800 && convBusy; endproperty
  a_msb: assert property (p_msb) else $error("first trial not msb");
  property p_pin; port0Bit5 == (convBusy && port0Bit5Oe); endproperty
  a_pin: assert property (p_pin) else $error("port pin mismatch");
endmodule
`default_nettype wire

//--- verif/sadc_afe_model.sv
/*
  behavioural front end: comparator against a held input code,
  temperature sensor as a fixed code.
  assumes the interface trial code settles within one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_afe_model #(
  parameter logic [11:0] TEMP_CODE = 12'h4d2
) (
  // interface face
  input wire sadc_pkg::sadc_afe_type afe,
  input wire logic [11:0] vin,
  // comparator
  output logic comp
);
  logic [11:0] level;
  // sensor replaces the pin input when selected
  assign level = afe.tempSel ? TEMP_CODE : vin;
  // input half a step above level; inverted junk while tracking
  assign comp = (level >= afe.dacCode) ^ afe.track;
endmodule
`default_nettype wire

//--- verif/sadc_interface_tb.sv
/*
  self-checking bench for the converter interface.
  assumes the front end model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_interface_tb;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam int ACQ = 2;
  localparam logic [11:0] TEMP = 12'h4d2;
  logic clk, arst_n, ce, comp, busReady, convIrq, convBusy, p5, p5Oe;
  logic [3:0] trig;
  logic [11:0] vin;
  logic [31:0] rdata, rd, res;
  sadc_pkg::sadc_bus_type bus;
  sadc_pkg::sadc_afe_type afe;
  int errorCnt, checksDone;

  sadc_interface #(.ACQ(ACQ)) uut (.clk(clk), .arst_n(arst_n), .ce(ce), .bus(bus),
    .busRdata(rdata), .busReady(busReady), .extConvertTrigger(trig[0]),
    .logicArrayStart(trig[1]), .timerAOverflow(trig[2]), .timerBOverflow(trig[3]),
    .comp(comp), .afe(afe), .convIrq(convIrq), .convBusy(convBusy),
    .port0Bit5(p5), .port0Bit5Oe(p5Oe));
  sadc_afe_model #(.TEMP_CODE(TEMP)) afeModel (.afe(afe), .vin(vin), .comp(comp));

  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    errorCnt++;
    completeRun();
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // setup cycle, access cycle, data taken where ready is seen
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    bus <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    bus.en <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busReady !== 1'b1 && n < 8);
    chk("bus ready", 32'h1, {31'h0, busReady});
    rd = rdata;
    bus.sel <= 1'b0;
    bus.en <= 1'b0;
  endtask
  // program, trigger, wait for ready, fetch result
  task automatic conv(input logic [11:0] v, input logic [7:0] ctl);
    int n;
    vin <= v;
    acc(1'b1, sadc_pkg::ADDR_CONTROL, {24'h0, ctl});
    if (ctl[5:3] > 3'h2) begin
      trig[ctl[5:3] - 3'h3] <= 1'b1;
      @(posedge clk);
      trig <= 4'h0;
    end
    n = 0;
    while (convIrq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      if (convBusy === 1'b1) chk("busy pin", {31'h0, ctl[0]}, {31'h0, p5});
    end
    chk("conversion end", 32'h1, {31'h0, convIrq});
    chk("busy pin enable", {31'h0, ctl[0]}, {31'h0, p5Oe});
    acc(1'b0, sadc_pkg::ADDR_STATUS, 32'h0);
    chk("ready flag", 32'h1, rd);
    acc(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
    res = rd;
    acc(1'b0, sadc_pkg::ADDR_STATUS, 32'h0);
    chk("ready cleared", 32'h0, rd);
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] adr [7];
    logic [31:0] exp [7];
    adr = '{sadc_pkg::ADDR_STATUS, sadc_pkg::ADDR_RESULT, sadc_pkg::ADDR_SOFT_RST,
      sadc_pkg::ADDR_GAIN, sadc_pkg::ADDR_OFFSET, sadc_pkg::ADDR_NEG_SEL, 32'hffff0520};
    exp = '{32'h0, 32'h0, 32'h0, 32'h200, 32'h200, 32'h0, 32'h0};
    acc(1'b1, sadc_pkg::ADDR_RESULT, 32'hffffffff);
    acc(1'b1, 32'hffff0520, 32'hffffffff);
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, adr[i], 32'h0);
      chk("default value", exp[i], rd);
    end
    $display("reset values done");
  endtask
  // every start source, busy pin on and off, single and pseudo
  task automatic t_starts();
    logic [2:0] s [6];
    int n;
    s = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h2};
    for (int i = 0; i < 6; i++) begin
      conv(12'hfff >> i, {2'b00, s[i], i[0] ? 2'h2 : 2'h0, ~i[0]});
      chk("straight result", {4'h0, 12'hfff >> i, 16'h0}, res);
    end
    acc(1'b1, sadc_pkg::ADDR_CONTROL, 32'h0);
    n = 0;
    while (convIrq !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    acc(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
    $display("start sources done");
  endtask
  task automatic t_diff();
    conv(12'h900, 8'h0a);
    chk("diff positive", 32'h00800000, res);
    chk("mode wire", {30'h0, sadc_pkg::MODE_DIFF}, {30'h0, afe.mode});
    conv(12'h000, 8'h0a);
    chk("diff most negative", 32'hfc000000, res);
    $display("differential done");
  endtask
  task automatic t_mux();
    acc(1'b1, sadc_pkg::ADDR_NEG_SEL, 32'hffffffff);
    acc(1'b0, sadc_pkg::ADDR_NEG_SEL, 32'h0);
    chk("neg select read", 32'h1f, rd);
    chk("neg select wire", 32'h1f, {27'h0, afe.negSel});
    acc(1'b1, sadc_pkg::ADDR_POS_SEL, 32'h10);
    // let the select register settle before looking at the wires
    @(posedge clk);
    chk("sensor select", 32'h1, {31'h0, afe.tempSel});
    chk("pos select wire", 32'h10, {27'h0, afe.posSel});
    conv(12'h0, 8'h08);
    chk("sensor result", {4'h0, TEMP, 16'h0}, res);
    acc(1'b1, sadc_pkg::ADDR_POS_SEL, 32'h0);
    $display("mux select done");
  endtask
  // single trim steps, then a software offset search
  task automatic t_cal();
    logic [9:0] t;
    logic ok;
    int n;
    acc(1'b1, sadc_pkg::ADDR_GAIN, 32'h208);
    conv(12'h800, 8'h08);
    chk("gain step", 32'h08010000, res);
    acc(1'b1, sadc_pkg::ADDR_GAIN, 32'h200);
    t = 10'h20c;
    acc(1'b1, sadc_pkg::ADDR_OFFSET, {22'h0, t});
    conv(12'h0, 8'h08);
    chk("offset step", 32'h00030000, res);
    n = 0;
    while (res[27:16] > 12'h1 && n < 20) begin
      t = t - 10'h1;
      acc(1'b1, sadc_pkg::ADDR_OFFSET, {22'h0, t});
      conv(12'h0, 8'h08);
      n++;
    end
    ok = res[27:16] < 12'h2 && t > 10'h204 && t < 10'h207;
    chk("offset search", 32'h1, {31'h0, ok});
    // gain search five codes short of full scale, offset back to neutral
    acc(1'b1, sadc_pkg::ADDR_OFFSET, 32'h200);
    conv(12'hffa, 8'h08);
    chk("gain start", 32'h0ffa0000, res);
    t = 10'h200;
    n = 0;
    while (res[27:16] < 12'hffe && n < 24) begin
      t = t + 10'h1;
      acc(1'b1, sadc_pkg::ADDR_GAIN, {22'h0, t});
      conv(12'hffa, 8'h08);
      n++;
    end
    ok = res[27:16] > 12'hffd && t > 10'h20c && t < 10'h212;
    chk("gain search", 32'h1, {31'h0, ok});
    acc(1'b1, sadc_pkg::ADDR_GAIN, 32'h200);
    $display("calibration done");
  endtask
  task automatic t_soft();
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    acc(1'b1, sadc_pkg::ADDR_GAIN, 32'h3ff);
    ce <= 1'b1;
    acc(1'b0, sadc_pkg::ADDR_GAIN, 32'h0);
    chk("gain frozen", 32'h200, rd);
    acc(1'b1, sadc_pkg::ADDR_GAIN, 32'hfffffd55);
    acc(1'b0, sadc_pkg::ADDR_GAIN, 32'h0);
    chk("gain width", 32'h155, rd);
    acc(1'b1, sadc_pkg::ADDR_NEG_SEL, 32'h5);
    acc(1'b1, sadc_pkg::ADDR_SOFT_RST, 32'h5a);
    t_reset();
    chk("neg select cleared", 32'h0, {27'h0, afe.negSel});
    $display("soft reset done");
  endtask

  // reset, then the scenarios in order
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    trig = 4'h0;
    vin = 12'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_starts();
    t_diff();
    t_mux();
    t_cal();
    t_soft();
    completeRun();
  end
endmodule

bind sadc_interface sadc_interface_props #(.ACQ(ACQ)) props (.clk, .arst_n, .ce, .bus,
  .busRdata, .busReady, .convIrq, .convBusy, .port0Bit5, .port0Bit5Oe, .afe);
`default_nettype wire
